// ===== rtl/asop_pkg.sv
/*
 Package for the sample output port of a 12-bit pipelined converter.
 Holds widths, pipeline depth, rates and the data carrier struct.
 Assumes a single 250 MHz system clock.
*/
package asop_pkg;
	// ==========================================================
	// Widths and depths
	localparam int ASOP_WORD_W = 12;
	localparam int ASOP_FIFO_DEPTH = 32;
	localparam int ASOP_PIPE_DEPTH = 6;
	// ==========================================================
	// Timing
	localparam int ASOP_CLK_MHZ = 250;
	localparam int ASOP_SAMPLE_MSPS = 40;
	// Shortest sample period rounds down to whole cycles
	localparam int ASOP_SAMPLE_CYC = ASOP_CLK_MHZ / ASOP_SAMPLE_MSPS;
	// ==========================================================
	// Offset binary midscale (zero differential input)
	localparam logic [11:0] ASOP_MIDSCALE = 12'h0800;
	localparam logic [11:0] ASOP_WORD_RST = 12'h0000;

	// Sample word as carried through the pipeline and FIFO
	typedef struct packed {
		logic [11:0] code;
		logic fresh;
	} asop_sample_t;
endpackage : asop_pkg

// ===== rtl/asop_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module asop_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// ==========================================================
	// Honest flags from the occupancy count
	assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem[rd_reg];

	// Storage has no reset; only pointers and count matter
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) wr_reg <= AW'(wr_reg + 1'b1);
			if (pop) rd_reg <= AW'(rd_reg + 1'b1);
			cnt_reg <= (AW+1)'(cnt_reg + push - pop);
		end
	end
endmodule : asop_fifo

// ===== rtl/asop_port.sv
/*
 Digital output side of a 12-bit pipelined converter: samples on the
 sample clock, pipelines, buffers in a FIFO, drives three-state outputs.
 Assumes the analog front end delivers a ready two's-complement code.
*/
// Behaviour
// - Capture the analog value on every rising sample clock edge while active.
// - Output enable low drives data; high floats all twelve data outputs.
// - Shutdown request high enters power-down; low returns to active conversion.
// - Result is a 12-bit offset-binary word, monotonic with input.
// - Sustain 40 Msps; capturer takes one word per sample clock.
// - Output bit zero is the LSB, bit eleven the MSB.
`timescale 1ns/100ps
module asop_port
	import asop_pkg::*;
#(
	parameter int PIPE_DEPTH = ASOP_PIPE_DEPTH,
	parameter int FIFO_DEPTH = ASOP_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pins from capturing logic, synchronous to clk
	input wire logic sample_clk,
	input wire logic output_enable_n,
	input wire logic shutdown_request,
	// Converted analog level as signed two's complement
	input wire logic [11:0] analog_level,
	// Three-state data pins
	output logic [11:0] sample_word_out,
	output logic [11:0] sample_word_oe,
	output logic powered_down
);
	typedef enum logic [1:0] {
		ASOP_ACTIVE = 2'b00,
		ASOP_DOWN = 2'b01
	} asop_state_t;

	asop_state_t state_reg;
	logic sclk_prev_reg;
	asop_sample_t pipe_reg [PIPE_DEPTH];
	logic [11:0] word_reg;
	logic [11:0] oe_reg;
	logic pd_reg;
	logic fifo_valid;
	asop_sample_t fifo_out;

	// ==========================================================
	// Decode of edge, mode and conversion
	wire sample_edge = sample_clk && !sclk_prev_reg;
	wire active = (state_reg == ASOP_ACTIVE);
	wire take = sample_edge && active;
	// Two's complement to offset binary: flip sign bit keeps code monotonic
	wire [11:0] offset_code = analog_level ^ ASOP_MIDSCALE;
	wire asop_sample_t new_sample = '{code: offset_code, fresh: 1'b1};
	// Drain one word per sample edge so output stays paced to the clock
	wire drain = sample_edge && active;
	wire fifo_in_ready;

	// Edge detector on the synchronous sample clock
	always_ff @(posedge clk) begin
		if (reset) sclk_prev_reg <= 1'b0;
		else sclk_prev_reg <= sample_clk;
	end

	// Mode: level on shutdown_request picks the state directly
	always_ff @(posedge clk) begin
		if (reset) state_reg <= ASOP_ACTIVE;
		else begin
			unique case (state_reg)
				ASOP_ACTIVE: if (shutdown_request) state_reg <= ASOP_DOWN;
				ASOP_DOWN: if (!shutdown_request) state_reg <= ASOP_ACTIVE;
				default: state_reg <= ASOP_ACTIVE;
			endcase
		end
	end

	// ==========================================================
	// Conversion pipeline, one stage per sample edge; flushed in power-down
	// so stale words are marked not fresh while it refills.
	// Head stage split from the rest so no stage ever names index -1
	genvar gi;
	generate
		for (gi = 0; gi < PIPE_DEPTH; gi++) begin : g_pipe
			if (gi == 0) begin : g_head
				// Head stage loads the freshly converted code
				always_ff @(posedge clk) begin
					if (reset || !active) pipe_reg[gi] <= '0;
					else if (take) pipe_reg[gi] <= new_sample;
				end
			end else begin : g_body
				// Later stages shift one place per sample edge
				always_ff @(posedge clk) begin
					if (reset || !active) pipe_reg[gi] <= '0;
					else if (take) pipe_reg[gi] <= pipe_reg[gi-1];
				end
			end
		end
	endgenerate

	// Buffer between the pipeline and the pins
	asop_fifo #(
		.WIDTH($bits(asop_sample_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset(reset || !active),
		.in_valid(take),
		.in_ready(fifo_in_ready),
		.in_data(pipe_reg[PIPE_DEPTH-1]),
		.out_valid(fifo_valid),
		.out_ready(drain),
		.out_data(fifo_out)
	);

	// ==========================================================
	// Output register: one word per sample edge, bit 0 is LSB
	always_ff @(posedge clk) begin
		if (reset) begin
			word_reg <= ASOP_WORD_RST;
			oe_reg <= '0;
			pd_reg <= 1'b0;
		end else begin
			if (drain && fifo_valid) word_reg <= fifo_out.code;
			oe_reg <= {ASOP_WORD_W{!output_enable_n}};
			pd_reg <= !active;
		end
	end

	assign sample_word_out = word_reg;
	assign sample_word_oe = oe_reg;
	assign powered_down = pd_reg;

	// ==========================================================
	// Checks
	property p_oe_follows;
		@(posedge clk) disable iff (reset)
		1'b1 |=> (sample_word_oe == {12{!$past(output_enable_n)}});
	endproperty
	a_oe_follows: assert property (p_oe_follows) else $error("oe wrong");

	property p_float;
		@(posedge clk) disable iff (reset)
		output_enable_n [*2] |-> sample_word_oe == 12'h0000;
	endproperty
	a_float: assert property (p_float) else $error("outputs not floating");

	property p_pd_enter;
		@(posedge clk) disable iff (reset)
		shutdown_request |-> ##2 powered_down;
	endproperty
	a_pd_enter: assert property (p_pd_enter) else $error("no power-down");

	property p_pd_exit;
		@(posedge clk) disable iff (reset)
		!shutdown_request [*2] |-> ##1 !powered_down;
	endproperty
	a_pd_exit: assert property (p_pd_exit) else $error("no return to active");

	property p_offset;
		@(posedge clk) disable iff (reset)
		1'b1 |-> offset_code == {~analog_level[11], analog_level[10:0]};
	endproperty
	a_offset: assert property (p_offset) else $error("offset code wrong");

	property p_stage0;
		@(posedge clk) disable iff (reset)
		take && !shutdown_request |=> pipe_reg[0].code == $past(offset_code);
	endproperty
	a_stage0: assert property (p_stage0) else $error("sample not captured");

	property p_word;
		@(posedge clk) disable iff (reset)
		drain && fifo_valid |=> sample_word_out == $past(fifo_out.code);
	endproperty
	a_word: assert property (p_word) else $error("word not presented");

	property p_hold;
		@(posedge clk) disable iff (reset)
		!drain |=> $stable(sample_word_out);
	endproperty
	a_hold: assert property (p_hold) else $error("word changed off edge");

	// One push and one pop per edge: the buffer must never run out of room
	property p_room;
		@(posedge clk) disable iff (reset)
		take |-> fifo_in_ready;
	endproperty
	a_room: assert property (p_room) else $error("buffer full at sample edge");
endmodule : asop_port

// ===== sim/asop_capture.sv
/*
 Capturing logic model: makes the sample clock and latches words.
 Assumes it shares clk with the port and runs only while run is high.
*/
`timescale 1ns/100ps
module asop_capture #(
	parameter int SKIP = 7
) (
	// Clock and control
	input wire logic clk,
	input wire logic run,
	input wire logic [3:0] half,
	// Port pins
	output logic sample_clk,
	input wire logic [11:0] word,
	input wire logic [11:0] oe,
	output logic [11:0] pins,
	output logic [11:0] held
);
	logic [3:0] cnt = 4'h0;
	int fill = 0;
	// Released pins show the inverse, so a float never looks like data
	assign pins = (oe & word) | (~oe & ~word);
	// Sample clock parked low outside bursts; stale words skipped
	initial sample_clk = 1'b0;
	always @(posedge clk) begin
		#1;
		if (!run) begin
			cnt = 4'h0;
			fill = 0;
			sample_clk = 1'b0;
		end else if (cnt == half - 4'h1) begin
			cnt = 4'h0;
			sample_clk = ~sample_clk;
			if (sample_clk && fill < SKIP) fill++;
			else if (sample_clk) held = pins;
		end else cnt = cnt + 4'h1;
	end
endmodule : asop_capture

// ===== sim/asop_port_bench.sv
/*
 Bench for the converter output port: queue model against the words.
 Assumes asop_capture makes the sample clock.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module asop_port_bench;
	import asop_pkg::*;
	// ==========================================
	// Signals
	logic clk = 1'b0, reset = 1'b1, run = 1'b0, oen = 1'b1, oen_d = 1'b1;
	logic shut = 1'b0, prev = 1'b0, sample_clk, powered_down;
	logic [3:0] half = 4'h3;
	logic [11:0] level = 12'h0000, word, oe, pins, e;
	logic [11:0] q[$];
	int checks = 0, bad_count = 0, seed = 84085, n = 0;
	always #2 clk = ~clk;
	asop_port #(.PIPE_DEPTH(6), .FIFO_DEPTH(32)) dut (.clk(clk), .reset(reset),
		.sample_clk(sample_clk), .output_enable_n(oen), .shutdown_request(shut),
		.analog_level(level), .sample_word_out(word), .sample_word_oe(oe),
		.powered_down(powered_down));
	asop_capture cap (.clk(clk), .run(run), .half(half), .sample_clk(sample_clk),
		.word(word), .oe(oe), .pins(pins), .held());
	// Model: capture on sample rise, word due once the pipe has filled
	always @(posedge clk) begin
		prev <= sample_clk;
		oen_d <= oen;
		if (!reset) `CHK("oe", {12{~oen_d}}, oe)
		if (!reset && !shut && sample_clk && !prev) begin
			q.push_back({~level[11], level[10:0]});
			if (q.size() > ASOP_PIPE_DEPTH + 1) begin
				e = q.pop_front();
				fork
					automatic logic [11:0] x = e;
					begin @(posedge clk); #1; `CHK("word", x, word) end
				join_none
			end
		end
	end
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	// Random levels, full-scale corners first, enable toggled now and then
	task automatic stream(input int k);
		for (int i = 0; i < k; i++) begin
			n = $random(seed);
			level = (i < 4) ? {i[1], {11{i[0]}}} : n[11:0];
			if (i % 11 == 5) oen = n[12];
			tick(1);
		end
	endtask : stream
	// Outputs just after reset, before any sample edge reaches the buffer
	task automatic after_reset();
		`CHK("rst_word", ASOP_WORD_RST, word)
		`CHK("rst_pd", 1'b0, powered_down)
		`CHK("rst_oe", 12'h0000, oe)
	endtask : after_reset
	task automatic close_out();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	// Main sequence: 40 Msps, fastest rate, power-down and restart
	initial begin
		tick(8);
		reset = 1'b0;
		tick(1);
		after_reset();
		run = 1'b1;
		stream(240);
		run = 1'b0;
		tick(4);
		half = 4'h1;
		run = 1'b1;
		stream(120);
		run = 1'b0;
		tick(4);
		shut = 1'b1;
		tick(6);
		`CHK("pd", 1'b1, powered_down)
		q.delete();
		shut = 1'b0;
		tick(6);
		`CHK("pd", 1'b0, powered_down)
		run = 1'b1;
		stream(120);
		run = 1'b0;
		tick(4);
		close_out();
	end
	// Watchdog well past the expected run
	initial begin
		#20000;
		bad_count++;
		close_out();
	end
endmodule : asop_port_bench
